// ==== core/tucs_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucs_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_reg != (AW+1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rp_reg];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= (wp_reg == AW'(D-1)) ? '0 : wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= (rp_reg == AW'(D-1)) ? '0 : rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wp_reg] <= in_data;
        end
    end
endmodule // tucs_fifo
`default_nettype wire

// ==== core/tucs_pkg.sv ====
package tucs_pkg;

    localparam int TUCS_DATA_W    = 9;
    localparam int TUCS_FIFO_D    = 4;
    localparam int TUCS_STRB_CYC  = 2;
    localparam logic TUCS_RST_BIT = 1'b0;

    // Reset values
    localparam logic [8:0] TUCS_DATA_RST = 9'h000;
    localparam logic [1:0] TUCS_CNT_RST  = 2'h0;

    // Register map of the plain port
    localparam logic [3:0] TUCS_A_CTRL   = 4'h0;
    localparam logic [3:0] TUCS_A_STATUS = 4'h1;
    localparam logic [3:0] TUCS_A_CONFIG = 4'h2;

    // Control register bit positions
    localparam int TUCS_C_WARM   = 0;
    localparam int TUCS_C_UNLOAD = 1;
    localparam int TUCS_C_LOWSPD = 2;

    // Config register bit positions
    localparam int TUCS_G_NINE   = 0;
    localparam int TUCS_G_PE     = 1;
    localparam int TUCS_G_DUAL   = 2;

    typedef enum logic [1:0] {
        TUCS_RD_IDLE  = 2'b00,
        TUCS_RD_STRB  = 2'b01,
        TUCS_RD_HOLD  = 2'b11
    } tucs_rd_e;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } tucs_bus_s;

    typedef struct packed {
        logic       parity;
        logic [7:0] data;
    } tucs_word_s;

endpackage

// ==== core/tucs_top.sv ====
// What this block does
// - Low speed select low runs lower speed
// - Write-arm flop set starts a write
// - Path complete when neither tape marker asserted
// - Unload flop asserted throughout unload sequence
// - Vacuum unload: unload flop and interlock open
// - Write permit follows lockout switch, drives protect
// - Write enable needs write-arm and tape motion
// - Track-count line asserted while selected
// - Write data held in register driving head
// - PE read data passed straight through
// - NRZI read data buffered with strobe
// - Select asserted when unit is addressed
// - Power clear resets unload and load flops
`timescale 1ns/1ps
`default_nettype none
module tucs_top (
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Register port
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [15:0]             reg_rdata,
    // Tape unit state
    input  wire logic               unit_addressed,
    input  wire logic               tape_start_marker,
    input  wire logic               tape_end_marker,
    input  wire logic               interlock_closed,
    input  wire logic               write_lockout_closed,
    input  wire logic               tape_motion,
    input  wire logic               load_fault,
    input  wire logic               load_start,
    input  wire logic               unload_done,
    // Write path
    input  wire tucs_pkg::tucs_word_s write_word,
    output tucs_pkg::tucs_word_s    write_head,
    // Read path
    input  wire tucs_pkg::tucs_word_s read_detect,
    input  wire logic               read_detect_valid,
    output tucs_pkg::tucs_word_s    read_word,
    output logic                    read_strobe,
    // Status lines
    output logic                    select_ind,
    output logic                    low_speed_select_n,
    output logic                    tape_path_complete,
    output logic                    unload_flop,
    output logic                    first_load_flop,
    output logic                    vacuum_unload_start,
    output logic                    write_permit,
    output logic                    file_protect_ind,
    output logic                    write_arm_flop,
    output logic                    write_electronics_enable,
    output logic                    seven_track_indicator,
    output logic                    nine_track_indicator,
    output logic                    read_overrun
);
    import tucs_pkg::*;

    logic [2:0]  cfg_reg;
    logic        lowspd_reg;
    logic        warm_reg;
    logic        unl_reg;
    logic        lda_reg;
    logic        por_done_reg;
    logic        ovr_reg;
    tucs_word_s  whead_reg;
    tucs_word_s  rword_reg;
    tucs_rd_e    rd_state_reg;
    tucs_rd_e    rd_state_next;
    logic [1:0]  strb_cnt_reg;
    logic [15:0] rdata_reg;
    logic        path_ok;
    logic        ctrl_wr;
    logic        f_out_valid;
    logic        f_out_ready;
    logic        f_in_ready;
    logic [TUCS_DATA_W-1:0] f_out_data;

    assign ctrl_wr = reg_wr && (reg_addr == TUCS_A_CTRL);
    assign path_ok = !tape_start_marker && !tape_end_marker;

    // Configuration register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= 3'h0;
        end else if (reg_wr && (reg_addr == TUCS_A_CONFIG)) begin
            cfg_reg <= reg_wdata[2:0];
        end
    end

    // Speed selection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowspd_reg <= 1'b0;
        end else if (ctrl_wr) begin
            lowspd_reg <= reg_wdata[TUCS_C_LOWSPD];
        end
    end
    assign low_speed_select_n = !(lowspd_reg && cfg_reg[TUCS_G_DUAL]);

    // Write-arm flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            warm_reg <= 1'b0;
        end else if (ctrl_wr) begin
            warm_reg <= reg_wdata[TUCS_C_WARM];
        end
    end
    assign write_arm_flop           = warm_reg;
    assign write_electronics_enable = warm_reg && tape_motion;

    // Unload and first load flops, cleared at power-up
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            unl_reg      <= 1'b0;
            lda_reg      <= 1'b0;
            por_done_reg <= 1'b0;
        end else begin
            por_done_reg <= 1'b1;
            if (!por_done_reg && !path_ok && load_fault) begin
                unl_reg <= 1'b0;
                lda_reg <= 1'b0;
            end else begin
                if (ctrl_wr && reg_wdata[TUCS_C_UNLOAD]) begin
                    unl_reg <= 1'b1;
                end else if (unload_done) begin
                    unl_reg <= 1'b0;
                end
                if (load_start && !unl_reg) begin
                    lda_reg <= 1'b1;
                end else if (unl_reg || path_ok) begin
                    lda_reg <= 1'b0;
                end
            end
        end
    end
    assign unload_flop         = unl_reg;
    assign first_load_flop     = lda_reg;
    assign vacuum_unload_start = unl_reg && !interlock_closed;

    assign tape_path_complete = path_ok;
    assign write_permit       = write_lockout_closed;
    assign file_protect_ind   = !write_lockout_closed;

    assign select_ind            = unit_addressed;
    assign seven_track_indicator = unit_addressed && !cfg_reg[TUCS_G_NINE];
    assign nine_track_indicator  = unit_addressed && cfg_reg[TUCS_G_NINE];

    // Write holding register
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            whead_reg <= TUCS_DATA_RST;
        end else if (write_electronics_enable) begin
            whead_reg <= write_word;
        end
    end
    assign write_head = whead_reg;

    // NRZI read buffer
    tucs_fifo #(
        .W (TUCS_DATA_W),
        .D (TUCS_FIFO_D)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (read_detect_valid && !cfg_reg[TUCS_G_PE]),
        .in_ready  (f_in_ready),
        .in_data   (read_detect),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );
    assign f_out_ready = (rd_state_reg == TUCS_RD_IDLE);

    // Lost read characters when buffer is full
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ovr_reg <= 1'b0;
        end else if (read_detect_valid && !cfg_reg[TUCS_G_PE] && !f_in_ready) begin
            ovr_reg <= 1'b1;
        end else if (reg_rd && (reg_addr == TUCS_A_STATUS)) begin
            ovr_reg <= 1'b0;
        end
    end
    assign read_overrun = ovr_reg;

    // Strobe sequencer
    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            TUCS_RD_IDLE: begin
                if (f_out_valid) begin
                    rd_state_next = TUCS_RD_STRB;
                end
            end
            TUCS_RD_STRB: begin
                rd_state_next = TUCS_RD_HOLD;
            end
            TUCS_RD_HOLD: begin
                if (strb_cnt_reg == 2'(TUCS_STRB_CYC - 1)) begin
                    rd_state_next = TUCS_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = TUCS_RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_state_reg <= TUCS_RD_IDLE;
            strb_cnt_reg <= TUCS_CNT_RST;
        end else begin
            rd_state_reg <= rd_state_next;
            strb_cnt_reg <= (rd_state_reg == TUCS_RD_HOLD) ? strb_cnt_reg + 2'h1
                                                           : TUCS_CNT_RST;
        end
    end

    // Read output word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rword_reg <= TUCS_DATA_RST;
        end else if (cfg_reg[TUCS_G_PE]) begin
            rword_reg <= read_detect;
        end else if (f_out_valid && f_out_ready) begin
            rword_reg <= f_out_data;
        end
    end
    assign read_word   = cfg_reg[TUCS_G_PE] ? read_detect : rword_reg;
    assign read_strobe = (rd_state_reg == TUCS_RD_STRB) && !cfg_reg[TUCS_G_PE];

    // Register read data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                TUCS_A_CTRL:   rdata_reg <= {13'h0000, lowspd_reg, unl_reg, warm_reg};
                TUCS_A_STATUS: rdata_reg <= {8'h00, ovr_reg, lda_reg, tape_motion,
                                             write_permit, write_electronics_enable,
                                             vacuum_unload_start, path_ok, select_ind};
                TUCS_A_CONFIG: rdata_reg <= {13'h0000, cfg_reg};
                default:       rdata_reg <= 16'h0000;
            endcase
        end else begin
            rdata_reg <= 16'h0000;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule // tucs_top
`default_nettype wire

// ==== sim/tucs_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucs_formatter (
    input wire logic                 clk_sys,
    input wire logic                 write_electronics_enable,
    input wire logic                 read_strobe,
    input wire tucs_pkg::tucs_word_s read_word,
    output tucs_pkg::tucs_word_s     write_word,
    output logic [7:0]               rd_cnt,
    output tucs_pkg::tucs_word_s     rd_last
);
    import tucs_pkg::*;
    initial begin
        write_word = 9'h0a5;
        rd_cnt = 8'h00;
        rd_last = 9'h000;
    end
    // New word only while enabled, else a changing pattern
    always @(posedge clk_sys) begin
        if (write_electronics_enable) begin
            write_word <= tucs_word_s'(write_word + 9'h001);
        end else begin
            write_word <= ~write_word;
        end
        if (read_strobe) begin
            rd_cnt <= rd_cnt + 8'h01;
            rd_last <= read_word;
        end
    end
endmodule // tucs_formatter
`default_nettype wire

// ==== sim/tucs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucs_properties (
    input wire logic                 clk_sys,
    input wire logic                 rst_n,
    input wire logic                 unit_addressed,
    input wire logic                 tape_start_marker,
    input wire logic                 tape_end_marker,
    input wire logic                 interlock_closed,
    input wire logic                 write_lockout_closed,
    input wire logic                 tape_motion,
    input wire tucs_pkg::tucs_word_s write_word,
    input wire tucs_pkg::tucs_word_s write_head,
    input wire logic                 read_strobe,
    input wire logic                 select_ind,
    input wire logic                 tape_path_complete,
    input wire logic                 unload_flop,
    input wire logic                 vacuum_unload_start,
    input wire logic                 write_permit,
    input wire logic                 file_protect_ind,
    input wire logic                 write_arm_flop,
    input wire logic                 write_electronics_enable,
    input wire logic                 seven_track_indicator,
    input wire logic                 nine_track_indicator
);
    import tucs_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // Quiet cycles after a strobe
    sequence s_gap;
        !read_strobe [*3];
    endsequence
    a_path_complete: assert property (tape_path_complete == !(tape_start_marker || tape_end_marker))
        else $error("path complete wrong");
    a_vacuum_unload: assert property (vacuum_unload_start == (unload_flop && !interlock_closed))
        else $error("vacuum unload wrong");
    a_permit_lamp: assert property (write_permit == write_lockout_closed && file_protect_ind != write_permit)
        else $error("write permit wrong");
    a_write_enable: assert property (write_electronics_enable == (write_arm_flop && tape_motion))
        else $error("write enable wrong");
    a_track_line: assert property ((seven_track_indicator ^ nine_track_indicator) == unit_addressed)
        else $error("track line wrong");
    a_select_unit: assert property (select_ind == unit_addressed)
        else $error("select wrong");
    a_head_capture: assert property (write_electronics_enable |=> write_head == $past(write_word))
        else $error("head capture wrong");
    a_head_holds: assert property (!write_electronics_enable |=> $stable(write_head))
        else $error("head changed");
    a_strobe_gap: assert property (read_strobe |=> s_gap)
        else $error("strobe too close");
endmodule // tucs_properties
bind tucs_top tucs_properties tucs_properties_inst (.*);
`default_nettype wire

// ==== sim/tucs_top_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module tucs_top_test;
    import tucs_pkg::*;
    logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic unit_addressed = 1'b1, tape_start_marker = 1'b1, tape_end_marker = 1'b0;
    logic interlock_closed = 1'b0, write_lockout_closed = 1'b1, tape_motion = 1'b0;
    logic load_fault = 1'b1, load_start = 1'b0, unload_done = 1'b0, read_detect_valid = 1'b0;
    tucs_word_s write_word, write_head, read_word, rd_last, w;
    tucs_word_s read_detect = 9'h000;
    logic read_strobe, select_ind, low_speed_select_n, tape_path_complete, unload_flop;
    logic first_load_flop, vacuum_unload_start, write_permit, file_protect_ind;
    logic write_arm_flop, write_electronics_enable, seven_track_indicator;
    logic nine_track_indicator, read_overrun;
    logic [7:0] rd_cnt, base;
    int num_errors = 0, checks = 0;

    tucs_top tucs_top_inst (.*);
    tucs_formatter tucs_formatter_inst (.*);

    always #2 clk_sys = ~clk_sys;

    task automatic complete_run;
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(n, e, reg_rdata);
    endtask

    task automatic t_regs;
        chk("spd_n", 16'h0001, 16'(low_speed_select_n));
        chk("trk7", 16'h0001, 16'(seven_track_indicator));
        rd(4'hf, 16'h0000, "unmapped");
        rd(TUCS_A_STATUS, 16'h0013, "status");
        wr(TUCS_A_CONFIG, 16'h0004);
        wr(TUCS_A_CTRL, 16'h0004);
        chk("spd_n", 16'h0000, 16'(low_speed_select_n));
        wr(TUCS_A_CONFIG, 16'h0000);
        chk("spd_n", 16'h0001, 16'(low_speed_select_n));
    endtask

    task automatic t_unload;
        wr(TUCS_A_CTRL, 16'h0002);
        chk("unl", 16'h0001, 16'(unload_flop));
        chk("vac", 16'h0001, 16'(vacuum_unload_start));
        @(posedge clk_sys) interlock_closed <= 1'b1;
        @(posedge clk_sys) unload_done <= 1'b1;
        #1 chk("vac", 16'h0000, 16'(vacuum_unload_start));
        chk("unl", 16'h0001, 16'(unload_flop));
        @(posedge clk_sys) unload_done <= 1'b0;
        #1 chk("unl", 16'h0000, 16'(unload_flop));
        @(posedge clk_sys) begin
            tape_start_marker <= 1'b1;
            load_start <= 1'b1;
        end
        @(posedge clk_sys) load_start <= 1'b0;
        #1 chk("lda", 16'h0001, 16'(first_load_flop));
        @(posedge clk_sys) tape_start_marker <= 1'b0;
        @(posedge clk_sys);
        #1 chk("lda", 16'h0000, 16'(first_load_flop));
    endtask

    task automatic t_write;
        wr(TUCS_A_CONFIG, 16'h0001);
        chk("trk9", 16'h0001, 16'(nine_track_indicator));
        wr(TUCS_A_CTRL, 16'h0001);
        chk("arm", 16'h0001, 16'(write_arm_flop));
        chk("wen", 16'h0000, 16'(write_electronics_enable));
        @(posedge clk_sys) tape_motion <= 1'b1;
        @(posedge clk_sys);
        #1 chk("wen", 16'h0001, 16'(write_electronics_enable));
        w = write_word;
        @(posedge clk_sys) tape_motion <= 1'b0;
        #1 chk("head", 16'(w), 16'(write_head));
        wr(TUCS_A_CTRL, 16'h0000);
    endtask

    task automatic t_nrzi;
        base = rd_cnt;
        @(posedge clk_sys);
        read_detect <= 9'h1a5;
        read_detect_valid <= 1'b1;
        @(posedge clk_sys) read_detect_valid <= 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 chk("rdlast", 16'h01a5, 16'(rd_last));
        chk("rdcnt", 16'h0001, 16'(rd_cnt - base));
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            read_detect <= tucs_word_s'(9'h010 + 9'(i));
            read_detect_valid <= 1'b1;
        end
        @(posedge clk_sys) read_detect_valid <= 1'b0;
        repeat (40) @(posedge clk_sys);
        #1 chk("ovr", 16'h0001, 16'(read_overrun));
        rd(TUCS_A_STATUS, 16'h0093, "status");
        rd(TUCS_A_STATUS, 16'h0013, "status");
    endtask

    task automatic t_pe;
        wr(TUCS_A_CONFIG, 16'h0002);
        base = rd_cnt;
        @(posedge clk_sys);
        read_detect <= 9'h0c3;
        read_detect_valid <= 1'b1;
        #1 chk("peword", 16'h00c3, 16'(read_word));
        @(posedge clk_sys) read_detect_valid <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1 chk("pestrb", 16'h0000, 16'(rd_cnt - base));
    endtask

    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        reg_addr <= TUCS_A_CTRL;
        reg_wdata <= 16'h0002;
        reg_wr <= 1'b1;
        @(posedge clk_sys) reg_wr <= 1'b0;
        #1 chk("unl", 16'h0000, 16'(unload_flop));
        chk("lda", 16'h0000, 16'(first_load_flop));
        tape_start_marker <= 1'b0;
        load_fault <= 1'b0;
        t_regs();
        t_unload();
        t_write();
        t_nrzi();
        t_pe();
        complete_run();
    end

    initial begin
        #20000;
        num_errors++;
        complete_run();
    end
endmodule // tucs_top_test
`default_nettype wire
